// File: src/bbce_pkg.sv
// Constants and types shared by the branch, bit and control executor
package bbce_pkg;

    // ************************************************************
    // Widths and field positions
    // ************************************************************
    localparam int PC_W     = 12;
    localparam int DISP_LSB = 3;
    localparam int POL_POS  = 4;
    localparam int BIDX_LSB = 5;
    localparam int HI_LSB   = 4;

    // ************************************************************
    // Opcode encodings (first byte)
    // ************************************************************
    localparam logic [2:0] COND_NZ = 3'h0;
    localparam logic [2:0] COND_Z  = 3'h4;
    localparam logic [2:0] COND_NC = 3'h2;
    localparam logic [2:0] COND_C  = 3'h6;
    localparam logic [3:0] LO_BTB  = 4'h3;
    localparam logic [3:0] LO_BIT  = 4'hb;
    localparam logic [3:0] LO_CALL = 4'h1;
    localparam logic [3:0] LO_JUMP = 4'h9;
    localparam logic [3:0] LO_INH  = 4'hd;
    localparam logic [3:0] INH_NOP  = 4'h0;
    localparam logic [3:0] INH_RET  = 4'hc;
    localparam logic [3:0] INH_INTERRUPT_RETURN = 4'hd;
    localparam logic [3:0] INH_HALT = 4'h6;
    localparam logic [3:0] INH_IDLE = 4'he;

    // ************************************************************
    // Lengths, cycle counts and execution steps
    // ************************************************************
    localparam logic [1:0] LEN_ONE   = 2'h1;
    localparam logic [1:0] LEN_TWO   = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam logic [2:0] CYC_SHORT = 3'h2;
    localparam logic [2:0] CYC_BTB   = 3'h5;
    localparam logic [2:0] CYC_BIT   = 3'h4;
    localparam logic [2:0] CYC_INH   = 3'h2;
    localparam logic [2:0] CYC_JMP   = 3'h4;
    localparam logic [2:0] STEP_READ = 3'h0;
    localparam logic [2:0] STEP_DATA = 3'h1;
    localparam logic [2:0] STEP_USE  = 3'h2;
    localparam logic [2:0] STEP_ONE  = 3'h1;

    // Displacements are relative to the branch plus these biases
    localparam logic [PC_W-1:0] SHORT_BIAS = 12'h001;
    localparam logic [PC_W-1:0] LONG_BIAS  = 12'h002;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } bbce_state_t;

    typedef enum logic [3:0] {
        OP_NONE, OP_SHORT, OP_BTB, OP_BIT, OP_CALL, OP_JUMP,
        OP_NOP, OP_RET, OP_INTERRUPT_RETURN, OP_HALT, OP_IDLE
    } bbce_op_t;

    function automatic logic [PC_W-1:0] sext5(input logic [4:0] d);
        return {{(PC_W-5){d[4]}}, d};
    endfunction

    function automatic logic [PC_W-1:0] sext8(input logic [7:0] d);
        return {{(PC_W-8){d[7]}}, d};
    endfunction

endpackage

// File: src/bbce_bit_if.sv
// Carrier between the executor and its bit unit
`timescale 1ns/1ps
interface bbce_bit_if;
    logic       loadEn;
    logic [7:0] dataIn;
    logic [2:0] bitIdx;
    logic       setBit;
    logic [7:0] result;
    logic       testedBit;

    modport exec (
        output loadEn,
        output dataIn,
        output bitIdx,
        output setBit,
        input  result,
        input  testedBit
    );

    modport unit (
        input  loadEn,
        input  dataIn,
        input  bitIdx,
        input  setBit,
        output result,
        output testedBit
    );
endinterface

// File: src/bbce_bit_unit.sv
// Bit unit: modifies or tests one bit of a data-space byte
`timescale 1ns/1ps
module bbce_bit_unit (
    input wire logic clk,
    input wire logic rst_n,
    bbce_bit_if.unit bu
);
    logic [7:0] mask;

    assign mask = 8'h01 << bu.bitIdx;

    // Only the selected bit changes; the rest passes through
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bu.result    <= 8'h00;
            bu.testedBit <= 1'b0;
        end else if (bu.loadEn) begin
            bu.result    <= bu.setBit ? (bu.dataIn | mask)
                                      : (bu.dataIn & ~mask);
            bu.testedBit <= bu.dataIn[bu.bitIdx];
        end
    end
endmodule

// File: src/bbce_exec.sv
// Executor for branch, bit, control and jump/call instructions
`timescale 1ns/1ps
module bbce_exec (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     instrValid,
    input  wire logic [7:0]               instrByte0,
    input  wire logic [7:0]               instrByte1,
    input  wire logic [7:0]               instrByte2,
    input  wire logic [bbce_pkg::PC_W-1:0] instrPc,
    output logic                          instrReady,
    input  wire logic                     watchdogSel,
    input  wire logic                     intEntry,
    input  wire logic                     flagWe,
    input  wire logic                     flagZIn,
    input  wire logic                     flagCIn,
    output logic [7:0]                    dataAddr,
    output logic                          dataRd,
    input  wire logic [7:0]               dataRdata,
    output logic                          dataWe,
    output logic [7:0]                    dataWdata,
    output logic                          busy,
    output logic                          execDone,
    output logic [1:0]                    instrLen,
    output logic                          pcLoad,
    output logic [bbce_pkg::PC_W-1:0]     pcTarget,
    output logic                          pushReturn,
    output logic                          popReturn,
    output logic                          haltReq,
    output logic                          idleReq,
    output logic                          unknownOp,
    output logic                          zFlag,
    output logic                          cFlag
);

    // ************************************************************
    // Decode of the first byte
    // ************************************************************
    bbce_pkg::bbce_op_t decOp;
    logic [2:0]         decCycles;
    logic [1:0]         decLen;
    logic [3:0]         lo;
    logic [3:0]         hi;

    assign lo = instrByte0[3:0];
    assign hi = instrByte0[bbce_pkg::HI_LSB +: 4];

    always_comb begin
        decOp     = bbce_pkg::OP_NONE;
        decCycles = bbce_pkg::CYC_INH;
        decLen    = bbce_pkg::LEN_ONE;
        if (instrByte0[2:0] == bbce_pkg::COND_NZ
            || instrByte0[2:0] == bbce_pkg::COND_Z
            || instrByte0[2:0] == bbce_pkg::COND_NC
            || instrByte0[2:0] == bbce_pkg::COND_C) begin
            decOp     = bbce_pkg::OP_SHORT;
            decCycles = bbce_pkg::CYC_SHORT;
        end else if (lo == bbce_pkg::LO_BTB) begin
            decOp     = bbce_pkg::OP_BTB;
            decCycles = bbce_pkg::CYC_BTB;
            decLen    = bbce_pkg::LEN_THREE;
        end else if (lo == bbce_pkg::LO_BIT) begin
            decOp     = bbce_pkg::OP_BIT;
            decCycles = bbce_pkg::CYC_BIT;
            decLen    = bbce_pkg::LEN_TWO;
        end else if (lo == bbce_pkg::LO_CALL
                     || lo == bbce_pkg::LO_JUMP) begin
            decOp     = (lo == bbce_pkg::LO_CALL) ? bbce_pkg::OP_CALL
                                                  : bbce_pkg::OP_JUMP;
            decCycles = bbce_pkg::CYC_JMP;
            decLen    = bbce_pkg::LEN_TWO;
        end else if (lo == bbce_pkg::LO_INH) begin
            case (hi)
                bbce_pkg::INH_NOP:  decOp = bbce_pkg::OP_NOP;
                bbce_pkg::INH_RET:  decOp = bbce_pkg::OP_RET;
                bbce_pkg::INH_INTERRUPT_RETURN: decOp = bbce_pkg::OP_INTERRUPT_RETURN;
                bbce_pkg::INH_HALT: decOp = bbce_pkg::OP_HALT;
                bbce_pkg::INH_IDLE: decOp = bbce_pkg::OP_IDLE;
                default:            decOp = bbce_pkg::OP_NONE;
            endcase
        end
    end

    // ************************************************************
    // Sequencing
    // ************************************************************
    bbce_pkg::bbce_state_t stateQ;
    bbce_pkg::bbce_op_t    opQ;
    logic [2:0]            stepQ;
    logic [2:0]            lastQ;
    logic [1:0]            lenQ;
    logic                  polQ;
    logic                  takenQ;
    logic [bbce_pkg::PC_W-1:0] targetQ;
    logic [7:0]            addrQ;
    logic [2:0]            bidxQ;
    logic                  accept;
    logic                  running;
    logic                  lastStep;
    logic                  condHolds;

    // Declared early: the branch decision reads the tested bit
    bbce_bit_if bu ();

    assign instrReady = (stateQ == bbce_pkg::ST_IDLE);
    assign accept     = instrReady && instrValid
                        && decOp != bbce_pkg::OP_NONE;
    assign running    = (stateQ == bbce_pkg::ST_RUN);
    assign lastStep   = running && stepQ == lastQ;
    assign unknownOp  = instrReady && instrValid
                        && decOp == bbce_pkg::OP_NONE;

    always_comb begin
        case (instrByte0[2:0])
            bbce_pkg::COND_C:  condHolds = cFlag;
            bbce_pkg::COND_NC: condHolds = !cFlag;
            bbce_pkg::COND_Z:  condHolds = zFlag;
            default:           condHolds = !zFlag;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= bbce_pkg::ST_IDLE;
            stepQ  <= bbce_pkg::STEP_READ;
        end else begin
            case (stateQ)
                bbce_pkg::ST_IDLE: begin
                    if (accept) begin
                        stateQ <= bbce_pkg::ST_RUN;
                        stepQ  <= bbce_pkg::STEP_READ;
                    end
                end
                bbce_pkg::ST_RUN: begin
                    if (lastStep) begin
                        stateQ <= bbce_pkg::ST_IDLE;
                    end
                    stepQ <= stepQ + bbce_pkg::STEP_ONE;
                end
                default: stateQ <= bbce_pkg::ST_IDLE;
            endcase
        end
    end

    // Instruction fields are latched once so the fetch side may move on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opQ   <= bbce_pkg::OP_NONE;
            lastQ <= bbce_pkg::STEP_READ;
            lenQ  <= bbce_pkg::LEN_ONE;
            polQ  <= 1'b0;
            addrQ <= 8'h00;
            bidxQ <= 3'h0;
        end else if (accept) begin
            opQ   <= decOp;
            lastQ <= decCycles - bbce_pkg::STEP_ONE;
            lenQ  <= decLen;
            polQ  <= instrByte0[bbce_pkg::POL_POS];
            addrQ <= instrByte1;
            bidxQ <= instrByte0[bbce_pkg::BIDX_LSB +: 3];
        end
    end

    // ************************************************************
    // Branch target and decision
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            targetQ <= 12'h000;
            takenQ  <= 1'b0;
        end else if (accept) begin
            case (decOp)
                bbce_pkg::OP_SHORT: begin
                    targetQ <= instrPc + bbce_pkg::SHORT_BIAS
                        + bbce_pkg::sext5(
                            instrByte0[bbce_pkg::DISP_LSB +: 5]);
                    takenQ  <= condHolds;
                end
                bbce_pkg::OP_BTB: begin
                    targetQ <= instrPc + bbce_pkg::LONG_BIAS
                        + bbce_pkg::sext8(instrByte2);
                    takenQ  <= 1'b0;
                end
                bbce_pkg::OP_CALL, bbce_pkg::OP_JUMP: begin
                    targetQ <= {instrByte0[bbce_pkg::HI_LSB +: 4],
                                instrByte1};
                    takenQ  <= 1'b1;
                end
                default: takenQ <= 1'b0;
            endcase
        end else if (running && opQ == bbce_pkg::OP_BTB
                     && stepQ == bbce_pkg::STEP_USE) begin
            // Polarity high means branch when the bit is set
            takenQ <= (bu.testedBit == polQ);
        end
    end

    // ************************************************************
    // Data-space access through the bit unit
    // ************************************************************
    logic bitOp;

    assign bitOp     = opQ == bbce_pkg::OP_BIT || opQ == bbce_pkg::OP_BTB;
    assign dataAddr  = addrQ;
    assign dataRd    = running && bitOp && stepQ == bbce_pkg::STEP_READ;
    assign bu.loadEn = running && bitOp && stepQ == bbce_pkg::STEP_DATA;
    assign bu.dataIn = dataRdata;
    assign bu.bitIdx = bidxQ;
    assign bu.setBit = polQ;
    // Write-back occurs only for set/clear; a test never disturbs memory
    assign dataWe    = running && opQ == bbce_pkg::OP_BIT
                       && stepQ == bbce_pkg::STEP_USE;
    assign dataWdata = bu.result;

    bbce_bit_unit i_bbce_bit_unit (
        .clk   (clk),
        .rst_n (rst_n),
        .bu    (bu)
    );

    // ************************************************************
    // Flags
    // ************************************************************
    logic zFlagQ;
    logic cFlagQ;
    logic savedZQ;
    logic savedCQ;

    assign zFlag = zFlagQ;
    assign cFlag = cFlagQ;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            savedZQ <= 1'b0;
            savedCQ <= 1'b0;
        end else if (intEntry) begin
            savedZQ <= zFlagQ;
            savedCQ <= cFlagQ;
        end
    end

    // Own updates win over the arithmetic side in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zFlagQ <= 1'b0;
            cFlagQ <= 1'b0;
        end else if (lastStep && opQ == bbce_pkg::OP_INTERRUPT_RETURN) begin
            zFlagQ <= savedZQ;
            cFlagQ <= savedCQ;
        end else if (running && opQ == bbce_pkg::OP_BTB
                     && stepQ == bbce_pkg::STEP_USE) begin
            cFlagQ <= bu.testedBit;
        end else if (flagWe) begin
            zFlagQ <= flagZIn;
            cFlagQ <= flagCIn;
        end
    end

    // ************************************************************
    // Completion outputs
    // ************************************************************
    logic haltOp;

    assign haltOp     = lastStep && opQ == bbce_pkg::OP_HALT;
    assign busy       = running;
    assign execDone   = lastStep;
    assign instrLen   = lenQ;
    assign pcTarget   = targetQ;
    assign pcLoad     = lastStep && takenQ;
    assign pushReturn = lastStep && opQ == bbce_pkg::OP_CALL;
    assign popReturn  = lastStep && (opQ == bbce_pkg::OP_RET
                                     || opQ == bbce_pkg::OP_INTERRUPT_RETURN);
    // Halt is unsafe with the watchdog running, so idle stands in
    assign haltReq    = haltOp && !watchdogSel;
    assign idleReq    = (lastStep && opQ == bbce_pkg::OP_IDLE)
                        || (haltOp && watchdogSel);

endmodule

// File: testbench/bbce_exec_asserts.sv
// Checker of the executor's port timing and results
`timescale 1ns/1ps
module bbce_exec_asserts (
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire logic                      instrValid,
    input wire logic [7:0]                instrByte0,
    input wire logic [7:0]                instrByte1,
    input wire logic [7:0]                instrByte2,
    input wire logic [bbce_pkg::PC_W-1:0] instrPc,
    input wire logic                      instrReady,
    input wire logic                      watchdogSel,
    input wire logic                      intEntry,
    input wire logic [7:0]                dataAddr,
    input wire logic                      dataRd,
    input wire logic [7:0]                dataRdata,
    input wire logic                      dataWe,
    input wire logic [7:0]                dataWdata,
    input wire logic                      busy,
    input wire logic                      execDone,
    input wire logic                      pcLoad,
    input wire logic [bbce_pkg::PC_W-1:0] pcTarget,
    input wire logic                      pushReturn,
    input wire logic                      popReturn,
    input wire logic                      haltReq,
    input wire logic                      idleReq,
    input wire logic                      unknownOp,
    input wire logic                      zFlag,
    input wire logic                      cFlag
);
    // ****************
    // Helper logic
    // ****************
    logic        acc;
    logic        rdPend_q;
    logic        take;
    logic [7:0]  b0_q, b1_q, b2_q, rd_q, modByte;
    logic [11:0] pc_q;
    logic [1:0]  zc_q, saved_q;
    assign acc = instrReady && instrValid && !unknownOp;
    // Condition uses the flags seen at acceptance, as the core does
    assign take = (b0_q[1] ? zc_q[0] : zc_q[1]) == b0_q[2];
    always_comb begin
        modByte = rd_q;
        modByte[b0_q[7:5]] = b0_q[4];
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {b0_q, b1_q, b2_q, rd_q, pc_q} <= '0;
            {zc_q, saved_q, rdPend_q} <= '0;
        end else begin
            if (acc) begin
                {b0_q, b1_q, b2_q, pc_q} <= {instrByte0, instrByte1,
                                             instrByte2, instrPc};
                zc_q <= {zFlag, cFlag};
            end
            rdPend_q <= dataRd;
            if (rdPend_q) rd_q <= dataRdata;
            if (intEntry) saved_q <= {zFlag, cFlag};
        end
    end
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_NO_ACCEPT_BUSY: assert property (
        busy |-> !instrReady && !unknownOp) else $error("ready while busy");
    AST_TWO_CYCLE: assert property (
        acc && (!instrByte0[0] || instrByte0[3:0] == bbce_pkg::LO_INH)
        |=> !execDone ##1 execDone) else $error("two cycle timing");
    AST_BTB_SEQ: assert property (
        acc && instrByte0[3:0] == bbce_pkg::LO_BTB
        |=> dataRd && dataAddr == b1_q ##1 !execDone [*3] ##1 execDone)
        else $error("bit test branch sequence");
    AST_BIT_SEQ: assert property (
        acc && instrByte0[3:0] == bbce_pkg::LO_BIT
        |=> dataRd && dataAddr == b1_q ##2 dataWe && dataWdata == modByte
        ##1 execDone) else $error("bit op sequence");
    AST_JUMP_CALL: assert property (
        acc && (instrByte0[3:0] == bbce_pkg::LO_CALL ||
                instrByte0[3:0] == bbce_pkg::LO_JUMP)
        |-> ##4 execDone && pcLoad && pcTarget == {b0_q[7:4], b1_q} &&
        pushReturn == (b0_q[3:0] == bbce_pkg::LO_CALL))
        else $error("jump or call result");
    AST_BTB_RESULT: assert property (
        execDone && b0_q[3:0] == bbce_pkg::LO_BTB
        |-> cFlag == rd_q[b0_q[7:5]] && zFlag == zc_q[1] &&
        pcLoad == (rd_q[b0_q[7:5]] == b0_q[4]) && (!pcLoad ||
        pcTarget == pc_q + 12'h002 + {{4{b2_q[7]}}, b2_q}))
        else $error("bit test branch result");
    AST_SHORT_RESULT: assert property (
        execDone && !b0_q[0] |-> pcLoad == take && {zFlag, cFlag} == zc_q
        && (!pcLoad || pcTarget == pc_q + 12'h001 + {{7{b0_q[7]}},
        b0_q[7:3]})) else $error("short branch result");
    AST_HALT_SWAP: assert property (
        execDone && b0_q == {bbce_pkg::INH_HALT, bbce_pkg::LO_INH}
        |-> haltReq == !watchdogSel && idleReq == watchdogSel)
        else $error("halt request kind");
    AST_POP: assert property (
        execDone && b0_q[3:0] == bbce_pkg::LO_INH |-> popReturn ==
        (b0_q[7:4] == bbce_pkg::INH_RET || b0_q[7:4] == bbce_pkg::INH_INTERRUPT_RETURN))
        else $error("return pop pulse");
    AST_INH_FLAGS: assert property (
        execDone && b0_q[3:0] == bbce_pkg::LO_INH |=> {zFlag, cFlag} ==
        ((b0_q[7:4] == bbce_pkg::INH_INTERRUPT_RETURN) ? saved_q : zc_q))
        else $error("control op flags");
endmodule

bind bbce_exec bbce_exec_asserts i_bbce_exec_asserts (
    .clk(clk), .rst_n(rst_n), .instrValid(instrValid),
    .instrByte0(instrByte0), .instrByte1(instrByte1),
    .instrByte2(instrByte2), .instrPc(instrPc), .instrReady(instrReady),
    .watchdogSel(watchdogSel), .intEntry(intEntry), .dataAddr(dataAddr),
    .dataRd(dataRd), .dataRdata(dataRdata), .dataWe(dataWe),
    .dataWdata(dataWdata), .busy(busy), .execDone(execDone),
    .pcLoad(pcLoad), .pcTarget(pcTarget), .pushReturn(pushReturn),
    .popReturn(popReturn), .haltReq(haltReq), .idleReq(idleReq),
    .unknownOp(unknownOp), .zFlag(zFlag), .cFlag(cFlag));

// File: testbench/tb_branch_bit_control_exec.sv
// Self-checking bench of the branch, bit and control executor
`timescale 1ns/1ps
module tb_branch_bit_control_exec;
    logic        clk = 1'b0, rst_n = 1'b0, instrValid = 1'b0;
    logic        watchdogSel = 1'b0, intEntry = 1'b0, flagWe = 1'b0;
    logic        flagZIn = 1'b0, flagCIn = 1'b0;
    logic [7:0]  instrByte0 = 8'h00, instrByte1 = 8'h00;
    logic [7:0]  instrByte2 = 8'h00, dataRdata = 8'h00;
    logic [11:0] instrPc = 12'h000;
    logic        instrReady, dataRd, dataWe, busy, execDone, pcLoad;
    logic        pushReturn, popReturn, haltReq, idleReq, unknownOp;
    logic        zFlag, cFlag, gotLoad, gotPush, gotPop, gotHalt, gotIdle;
    logic [7:0]  dataAddr, dataWdata, gotWd, gotAddr;
    logic [1:0]  instrLen, gotLen;
    logic [11:0] pcTarget, gotTgt, gotCyc;
    int          errorCnt = 0;
    int          nTests = 0;
    bbce_exec i_bbce_exec (.clk(clk), .rst_n(rst_n),
        .instrValid(instrValid), .instrByte0(instrByte0),
        .instrByte1(instrByte1), .instrByte2(instrByte2),
        .instrPc(instrPc), .instrReady(instrReady),
        .watchdogSel(watchdogSel), .intEntry(intEntry), .flagWe(flagWe),
        .flagZIn(flagZIn), .flagCIn(flagCIn), .dataAddr(dataAddr),
        .dataRd(dataRd), .dataRdata(dataRdata), .dataWe(dataWe),
        .dataWdata(dataWdata), .busy(busy), .execDone(execDone),
        .instrLen(instrLen), .pcLoad(pcLoad), .pcTarget(pcTarget),
        .pushReturn(pushReturn), .popReturn(popReturn),
        .haltReq(haltReq), .idleReq(idleReq), .unknownOp(unknownOp),
        .zFlag(zFlag), .cFlag(cFlag));
    always #5 clk = ~clk;
    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask
    task automatic set_flags(input logic z, input logic c);
        {flagWe, flagZIn, flagCIn} = {1'b1, z, c};
        @(posedge clk); #1;
        flagWe = 1'b0;
    endtask
    // Read data only follows a read by one cycle, inverted otherwise
    task automatic run(input logic [7:0] b0, b1, b2, rd,
                       input logic [11:0] pc);
        logic prev;
        prev = 1'b0;
        {instrByte0, instrByte1, instrByte2, instrPc} = {b0, b1, b2, pc};
        {instrValid, dataRdata, gotCyc} = {1'b1, ~rd, 12'h000};
        {gotAddr, gotWd} = 16'h0000;
        @(posedge clk); #1;
        instrValid = 1'b0;
        for (int k = 1; k < 12; k++) begin
            dataRdata = prev ? rd : ~rd;
            prev = dataRd;
            if (dataRd) gotAddr = dataAddr;
            if (dataWe) gotWd = dataWdata;
            if (execDone) begin
                gotCyc = k[11:0];
                {gotLoad, gotTgt, gotPush} = {pcLoad, pcTarget, pushReturn};
                {gotPop, gotHalt, gotIdle} = {popReturn, haltReq, idleReq};
                break;
            end
            @(posedge clk); #1;
        end
        @(posedge clk); #1;
        {gotLen, dataRdata} = {instrLen, ~rd};
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_short;
        logic take;
        for (int i = 0; i < 16; i++) begin
            set_flags(i[3], i[2]);
            take = (i[0] ? i[2] : i[3]) == i[1];
            run({i[0] ? 5'h10 : 5'h0f, i[1:0], 1'b0}, 8'h11, 8'h22, 8'h00,
                12'h800);
            chk(gotCyc, 12'h002);
            chk(gotLoad, take);
            if (take) chk(gotTgt, i[0] ? 12'h7f1 : 12'h810);
            chk({zFlag, cFlag}, i[3:2]);
            chk(gotLen, 2'h1);
        end
    endtask
    task automatic t_btb;
        for (int i = 0; i < 4; i++) begin
            set_flags(i[0], i[0]);
            run({i[0] ? 3'h7 : 3'h0, i[1], 4'h3}, 8'hc0 + 8'(i),
                i[1] ? 8'h80 : 8'h7f, i[0] ? 8'h7f : 8'h01, 12'h400);
            chk(gotCyc, 12'h005);
            chk(gotAddr, 8'hc0 + 8'(i));
            chk(gotLoad, !i[0] == i[1]);
            if (gotLoad) chk(gotTgt, i[1] ? 12'h382 : 12'h481);
            chk({zFlag, cFlag}, {i[0], !i[0]});
            chk(gotLen, 2'h3);
        end
    endtask
    task automatic t_bitop;
        logic [7:0] exp;
        for (int i = 0; i < 16; i++) begin
            set_flags(i[0], i[1]);
            exp = 8'ha5;
            exp[i[2:0]] = i[3];
            run({i[2:0], i[3], 4'hb}, 8'h30 + 8'(i), 8'h00, 8'ha5, 12'h100);
            chk(gotCyc, 12'h004);
            chk(gotAddr, 8'h30 + 8'(i));
            chk(gotWd, exp);
            chk({zFlag, cFlag, gotLen}, {i[0], i[1], 2'h2});
        end
    endtask
    task automatic t_jump;
        for (int i = 0; i < 2; i++) begin
            set_flags(i[0], !i[0]);
            run(i[0] ? 8'hf1 : 8'h59, i[0] ? 8'hff : 8'ha3, 8'h00, 8'h00,
                12'h234);
            chk(gotCyc, 12'h004);
            chk({gotLoad, gotPush, gotLen}, {1'b1, i[0], 2'h2});
            chk(gotTgt, i[0] ? 12'hfff : 12'h5a3);
            chk({zFlag, cFlag}, {i[0], !i[0]});
        end
    endtask
    // Flags saved at entry differ from live ones, so a restore shows
    task automatic t_ctrl;
        logic [3:0] hi [6];
        hi = '{4'h0, 4'hc, 4'hd, 4'h6, 4'h6, 4'he};
        for (int k = 0; k < 6; k++) begin
            set_flags(1'b1, 1'b0);
            intEntry = 1'b1;
            @(posedge clk); #1;
            intEntry = 1'b0;
            set_flags(1'b0, 1'b1);
            watchdogSel = (k == 4);
            run({hi[k], 4'hd}, 8'h00, 8'h00, 8'h00, 12'h010);
            chk(gotCyc, 12'h002);
            chk({gotLoad, gotLen}, 3'h1);
            chk(gotPop, k == 1 || k == 2);
            chk({gotHalt, gotIdle}, {k == 3, k > 3});
            chk({zFlag, cFlag}, k == 2 ? 2'h2 : 2'h1);
            watchdogSel = 1'b0;
        end
    endtask
    task automatic t_reset_unknown;
        chk({instrReady, gotLen, zFlag, cFlag}, 5'h14);
        chk(pcTarget, 12'h000);
        {instrByte0, instrValid} = {8'h05, 1'b1};
        #1;
        chk(unknownOp, 1'b1);
        @(posedge clk); #1;
        chk(busy, 1'b0);
        instrValid = 1'b0;
    endtask
    task automatic closeOut;
        if (errorCnt == 0 && nTests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #100us;
        errorCnt++;
        closeOut();
    end
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        gotLen = instrLen;
        t_reset_unknown();
        t_short();
        t_btb();
        t_bitop();
        t_jump();
        t_ctrl();
        closeOut();
    end
endmodule
